//--- tpm_assertions.sv
// Purpose: port-level checks on the timer block
// Assumes: one pclk domain, asynchronous active-low reset
// Notes:   APB answers with zero wait states
module tpm_chk
(
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Pins and requests
   input wire logic        timer_a_pulse_output,
   input wire logic        timer_a_irq,
   input wire logic        timer_b_irq
);
   // Access- and setup-phase decodes shared by the properties
   wire logic acc = psel & penable;
   wire logic irq_wr = acc & pwrite & (paddr == tpm_pkg::IRQ_OFS);
   wire logic rd_acc = psel & ~penable & ~pwrite;
   logic      a_pwm_ff;
   // Remembers modulation mode of timer A, whose data then reads as zero
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         a_pwm_ff <= 1'b0;
      else if (acc && pwrite && paddr == tpm_pkg::A_MODE_OFS)
         a_pwm_ff <= &pwdata[2:0];
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_high: assert property (psel |-> pready)
      else $error("pready low");
   a_err_unmapped: assert property
      (acc && paddr > tpm_pkg::IRQ_OFS |-> pslverr) else $error("no pslverr");
   a_err_mapped: assert property (acc && paddr <= tpm_pkg::IRQ_OFS &&
      paddr[1:0] == 2'h0 |-> !pslverr) else $error("spurious pslverr");
   a_rdata_hold: assert property (!rd_acc |=> $stable(prdata))
      else $error("prdata moved without a read");
   a_pwm_read_zero: assert property
      (rd_acc && paddr == tpm_pkg::A_DATA_OFS && a_pwm_ff |=> prdata == 32'h0)
      else $error("modulation read not zero");
   a_irqa_sticky: assert property
      (timer_a_irq && !(irq_wr && pwdata[0]) |=> timer_a_irq)
      else $error("timer A request lost");
   a_irqb_sticky: assert property
      (timer_b_irq && !(irq_wr && pwdata[1]) |=> timer_b_irq)
      else $error("timer B request lost");
   a_fall_irq: assert property
      ($fell(timer_a_pulse_output) |-> ##[0:2] timer_a_irq)
      else $error("no request at pulse fall");
endmodule
bind tpm_timer tpm_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_a_pulse_output,
   .timer_a_irq, .timer_b_irq);

//--- tpm_pin_model.sv
// Purpose: drives the trigger pin and the measured pulse pin
// Assumes: pins change right after a pclk edge
// Notes:   pulse halves are never shorter than two count clocks
module tpm_pin_model
(
   // Clock
   input wire logic clk,
   // Pins
   output logic     trig,
   output logic     bpin
);
   timeunit 1ns;
   timeprecision 1ps;
   // Known idle levels from time zero
   initial
   begin
      trig = 1'b0;
      bpin = 1'b1;
   end
   // One level change on the trigger pin
   task automatic set_trig(input logic v);
      @(posedge clk);
      trig <= v;
   endtask
   // n periods of fall, lo clocks low, rise, hi clocks high
   task automatic wave(input int hi, input int lo, input int n);
      int h;
      int l;
      h = (hi < 2) ? 2 : hi;
      l = (lo < 2) ? 2 : lo;
      repeat (n)
      begin
         @(posedge clk);
         bpin <= 1'b0;
         repeat (l) @(posedge clk);
         bpin <= 1'b1;
         repeat (h - 1) @(posedge clk);
      end
   endtask
endmodule

//--- tpm_pkg.sv
// Purpose: constants shared by the timer block and its bench
// Assumes: 32-bit APB, one word per register
// Notes:   offsets are byte addresses
package tpm_pkg;
   // Register byte offsets
   localparam logic [7:0] A_MODE_OFS  = 8'h00;
   localparam logic [7:0] A_DATA_OFS  = 8'h04;
   localparam logic [7:0] B_MODE_OFS  = 8'h08;
   localparam logic [7:0] B_DATA_OFS  = 8'h0c;
   localparam logic [7:0] START_OFS   = 8'h10;
   localparam logic [7:0] IRQ_OFS     = 8'h14;
   // Mode register fields
   localparam int MD_PWM0   = 0;
   localparam int MD_PWM2   = 2;
   localparam int MD_EDGE   = 3;
   localparam int MD_BIT2   = 2;
   localparam int MD_EXT    = 4;
   localparam int MD_LEN8   = 5;
   localparam int MD_OVF    = 5;
   localparam int MD_CLK_LO = 6;
   localparam int MD_CLK_HI = 7;
   // Start and request bits
   localparam int ST_A      = 0;
   localparam int ST_B      = 1;
   localparam int IRQ_A     = 0;
   localparam int IRQ_B     = 1;
   // B-type modes
   localparam logic [1:0] BM_TIMER = 2'h0;
   localparam logic [1:0] BM_EVENT = 2'h1;
   localparam logic [1:0] BM_MEAS  = 2'h2;
   // Reset values and phase end values
   localparam logic [7:0]  MODE_RST  = 8'h00;
   localparam logic [7:0]  BMODE_RST = 8'h20;
   localparam logic [15:0] CNT_RST   = 16'h0000;
   localparam logic [15:0] PERIOD16  = 16'hfffe;
   localparam logic [7:0]  PERIOD8   = 8'hfe;
   // Count clock dividers for clock select 0..3
   localparam logic [7:0] DIV0 = 8'h00;
   localparam logic [7:0] DIV1 = 8'h07;
   localparam logic [7:0] DIV2 = 8'h3f;
   localparam logic [7:0] DIV3 = 8'hff;
endpackage

//--- tpm_timer.sv
// Purpose: PWM timer (A type) and interval/event/measure timer (B type)
// Assumes: pins synchronous to pclk; APB slave with zero wait states
// Notes:   request bits are sticky; writing one clears, set wins
//
// How it works
// - A mode bit 5 picks 16-bit or 8-bit modulator with prescaler.
// - A mode bit 4 picks start bit or pin edge as start source.
// - A mode bit 3 picks falling or rising trigger edge.
// - Data write while halted loads reload register and counter.
// - Once running, triggers are ignored and output repeats forever.
// - 16-bit output high m counts of a 2^16-1 count period.
// - Request bit set on each falling edge of the pulse output while running; the fall on stop sets none.
// - Reload copied into counter just before next rising edge.
// - A data reads undefined in PWM mode; here reads zero.
// - 8-bit mode low byte prescales, pulse every n+1 clocks.
// - 8-bit mode high byte modulates, m high of 2^8-1 periods.
// - B mode bits 1:0 pick timer, event counter or measurement.
// - Timer mode decrements, at zero requests and reloads.
// - Write while running loads reload only; counter readable.
// - Event mode counts pin edges chosen by bits 3 and 2.
// - Bit 3 zero measures period, bit 2 picks edge polarity.
// - At each measured edge copy counter, clear, resume.
// - Request after each capture except first after start.
// - Bit 3 one measures width between opposite edges.
// - Measurement mode reads return the captured value.
// - Mode bit 5 overflow flag: set on measurement counter overflow and at reset, cleared by write.
//
// Local design decisions: the APB slave port and the register addresses.
module tpm_timer
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Pins
   input  wire logic        timer_a_trigger_input,
   input  wire logic        timer_b_input_pin,
   output logic             timer_a_pulse_output,
   // Interrupt requests
   output logic             timer_a_irq,
   output logic             timer_b_irq
);

   // Registers
   logic [7:0]  a_mode_ff, b_mode_ff;
   logic [15:0] a_rld_ff, a_cnt_ff, b_rld_ff, b_cnt_ff;
   logic [1:0]  start_ff, irq_ff;
   logic        a_run_ff, a_out_ff, a_trig_d_ff, b_in_d_ff, b_first_ff;
   logic [7:0]  a_div_ff, b_div_ff;
   logic [7:0]  a_pre_ff;
   logic [7:0]  a_ph8_ff;
   logic [15:0] a_ph16_ff;
   logic [31:0] prdata_ff;

   // Bus decode
   wire wr_en   = psel & penable & pwrite;
   // Read data is latched in the setup cycle so it stands at the access edge
   wire rd_en   = psel & ~penable & ~pwrite;
   wire sel_am  = paddr == tpm_pkg::A_MODE_OFS;
   wire sel_ad  = paddr == tpm_pkg::A_DATA_OFS;
   wire sel_bm  = paddr == tpm_pkg::B_MODE_OFS;
   wire sel_bd  = paddr == tpm_pkg::B_DATA_OFS;
   wire sel_st  = paddr == tpm_pkg::START_OFS;
   wire sel_irq = paddr == tpm_pkg::IRQ_OFS;
   wire mapped  = sel_am | sel_ad | sel_bm | sel_bd | sel_st | sel_irq;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata  = prdata_ff;

   // Count clock enables from a divider chosen by mode bits 7:6
   function automatic logic [7:0] div_of(input logic [1:0] s);
      logic [7:0] d;
      d = tpm_pkg::DIV0;
      unique case (s)
         2'h0: d = tpm_pkg::DIV0;
         2'h1: d = tpm_pkg::DIV1;
         2'h2: d = tpm_pkg::DIV2;
         2'h3: d = tpm_pkg::DIV3;
      endcase
      return d;
   endfunction
   wire [7:0] a_div_lim = div_of(a_mode_ff[tpm_pkg::MD_CLK_HI:
                                           tpm_pkg::MD_CLK_LO]);
   wire [7:0] b_div_lim = div_of(b_mode_ff[tpm_pkg::MD_CLK_HI:
                                           tpm_pkg::MD_CLK_LO]);
   wire a_tick = a_div_ff >= a_div_lim;
   wire b_tick = b_div_ff >= b_div_lim;

   // A-type decode
   wire a_pwm   = &a_mode_ff[tpm_pkg::MD_PWM2:tpm_pkg::MD_PWM0];
   wire a_len8  = a_mode_ff[tpm_pkg::MD_LEN8];
   wire a_ext   = a_mode_ff[tpm_pkg::MD_EXT];
   wire a_rise  = a_mode_ff[tpm_pkg::MD_EDGE];
   wire a_tedge = a_rise ? (timer_a_trigger_input & ~a_trig_d_ff)
                         : (~timer_a_trigger_input & a_trig_d_ff);
   wire a_en    = start_ff[tpm_pkg::ST_A] & a_pwm;
   // Running ignores triggers; ext mode waits for the edge
   wire a_go    = a_en & ~a_run_ff & (~a_ext | a_tedge);
   // 8-bit prescaler pulse every n+1 count clocks
   wire a_pre_hit = a_tick & (a_pre_ff == 8'h00);
   wire a_step    = a_len8 ? a_pre_hit : a_tick;
   wire a_ph16_end = a_ph16_ff == tpm_pkg::PERIOD16;
   wire a_ph8_end  = a_ph8_ff == tpm_pkg::PERIOD8;
   wire a_wrap     = a_len8 ? a_ph8_end : a_ph16_end;
   // High while phase is below the latched width
   wire a_hi16 = a_ph16_ff < a_cnt_ff;
   wire a_hi8  = a_ph8_ff < a_cnt_ff[15:8];
   wire nxt_a_out = a_run_ff & (a_len8 ? a_hi8 : a_hi16);
   wire a_fall = a_out_ff & ~nxt_a_out;

   // B-type decode
   wire [1:0] b_md = b_mode_ff[1:0];
   wire b_run  = start_ff[tpm_pkg::ST_B];
   wire b_b3   = b_mode_ff[tpm_pkg::MD_EDGE];
   wire b_b2   = b_mode_ff[tpm_pkg::MD_BIT2];
   wire b_rise = timer_b_input_pin & ~b_in_d_ff;
   wire b_fallp = ~timer_b_input_pin & b_in_d_ff;
   // Event edge select: 00 fall, 01 rise, 10 both
   wire b_ev_edge = b_b3 ? (b_rise | b_fallp)
                         : (b_b2 ? b_rise : b_fallp);
   // Period uses the same edge; width captures at every edge of either polarity
   wire b_meas_edge = b_b3 ? (b_rise | b_fallp)
                           : (b_b2 ? b_rise : b_fallp);
   wire b_dec  = b_run & ((b_md == tpm_pkg::BM_TIMER & b_tick) |
                          (b_md == tpm_pkg::BM_EVENT & b_ev_edge));
   wire b_zero_hit = b_dec & (b_cnt_ff == tpm_pkg::CNT_RST);
   wire b_meas = b_md == tpm_pkg::BM_MEAS;
   wire b_cap  = b_run & b_meas & b_meas_edge;
   wire b_minc = b_run & b_meas & b_tick & ~b_cap;
   wire b_movf = b_minc & (b_cnt_ff == 16'hffff);
   wire b_start_set = wr_en & sel_st & pwdata[tpm_pkg::ST_B] &
                      ~start_ff[tpm_pkg::ST_B];
   wire b_ev = b_zero_hit | (b_cap & ~b_first_ff);
   wire a_ev = a_run_ff & a_fall;

   // Read mux
   wire [15:0] a_rd = a_pwm ? 16'h0000 : a_cnt_ff;
   wire [15:0] b_rd = b_meas ? b_rld_ff : b_cnt_ff;
   wire [31:0] rd_mux =
      sel_am  ? {24'h0, a_mode_ff} :
      sel_ad  ? {16'h0, a_rd} :
      sel_bm  ? {24'h0, b_mode_ff} :
      sel_bd  ? {16'h0, b_rd} :
      sel_st  ? {30'h0, start_ff} :
      sel_irq ? {30'h0, irq_ff} : 32'h0;

   // Bus-side registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         a_mode_ff <= tpm_pkg::MODE_RST;
         start_ff  <= 2'h0;
         prdata_ff <= 32'h0;
      end
      else
      begin
         if (wr_en & sel_am)
            a_mode_ff <= pwdata[7:0];
         if (wr_en & sel_st)
            start_ff <= pwdata[1:0];
         if (rd_en)
            prdata_ff <= rd_mux;
      end
   end

   // Sticky requests: set beats a write-one clear
   wire [1:0] irq_clr = (wr_en & sel_irq) ? pwdata[1:0] : 2'h0;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_ff <= 2'h0;
      else
         irq_ff <= (irq_ff & ~irq_clr) | {b_ev, a_ev};
   end
   assign timer_a_irq = irq_ff[tpm_pkg::IRQ_A];
   assign timer_b_irq = irq_ff[tpm_pkg::IRQ_B];

   // Count clock dividers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         a_div_ff <= 8'h00;
         b_div_ff <= 8'h00;
      end
      else
      begin
         a_div_ff <= a_tick ? 8'h00 : a_div_ff + 8'h01;
         b_div_ff <= b_tick ? 8'h00 : b_div_ff + 8'h01;
      end
   end

   // A timer: reload, counter, prescaler, phase and output
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         a_rld_ff    <= tpm_pkg::CNT_RST;
         a_cnt_ff    <= tpm_pkg::CNT_RST;
         a_run_ff    <= 1'b0;
         a_out_ff    <= 1'b0;
         a_trig_d_ff <= 1'b0;
         a_pre_ff    <= 8'h00;
         a_ph8_ff    <= 8'h00;
         a_ph16_ff   <= 16'h0000;
      end
      else
      begin
         a_trig_d_ff <= timer_a_trigger_input;
         a_out_ff    <= nxt_a_out;
         if (wr_en & sel_ad)
         begin
            a_rld_ff <= pwdata[15:0];
            if (!a_run_ff)
               a_cnt_ff <= pwdata[15:0];
         end
         if (!a_en)
            a_run_ff <= 1'b0;
         else if (a_go)
         begin
            a_run_ff  <= 1'b1;
            a_ph16_ff <= 16'h0000;
            a_ph8_ff  <= 8'h00;
            a_pre_ff  <= a_rld_ff[7:0];
         end
         else if (a_run_ff)
         begin
            if (a_tick)
               a_pre_ff <= (a_pre_ff == 8'h00) ? a_rld_ff[7:0]
                                               : a_pre_ff - 8'h01;
            if (a_step)
            begin
               a_ph16_ff <= a_ph16_end ? 16'h0000 : a_ph16_ff + 16'h0001;
               a_ph8_ff  <= a_ph8_end ? 8'h00 : a_ph8_ff + 8'h01;
               if (a_wrap)
                  a_cnt_ff <= a_rld_ff;
            end
         end
      end
   end
   assign timer_a_pulse_output = a_out_ff;

   // B timer: mode, reload, counter, capture and overflow flag
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         b_mode_ff  <= tpm_pkg::BMODE_RST;
         b_rld_ff   <= tpm_pkg::CNT_RST;
         b_cnt_ff   <= tpm_pkg::CNT_RST;
         b_in_d_ff  <= 1'b0;
         b_first_ff <= 1'b1;
      end
      else
      begin
         b_in_d_ff <= timer_b_input_pin;
         if (wr_en & sel_bm)
            b_mode_ff <= {pwdata[7:6], b_movf, pwdata[4:0]};
         else if (b_movf)
            b_mode_ff[tpm_pkg::MD_OVF] <= 1'b1;
         if (b_start_set)
            b_first_ff <= 1'b1;
         else if (b_cap)
            b_first_ff <= 1'b0;
         if (b_cap)
         begin
            b_rld_ff <= b_cnt_ff;
            b_cnt_ff <= tpm_pkg::CNT_RST;
         end
         else if (b_minc)
            b_cnt_ff <= b_cnt_ff + 16'h0001;
         else if (b_dec)
            b_cnt_ff <= b_zero_hit ? b_rld_ff : b_cnt_ff - 16'h0001;
         if (wr_en & sel_bd & ~b_meas)
         begin
            b_rld_ff <= pwdata[15:0];
            if (!b_run)
               b_cnt_ff <= pwdata[15:0];
         end
      end
   end

endmodule

//--- tpm_timer_tb.sv
// Purpose: self-checking bench for the timer block
// Assumes: count clock select 0, one tick per pclk
// Notes:   measured counts allow one clock of edge latency
module tpm_timer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   `define CHK(g, w) begin checks_done++; if ((g) !== (w)) begin \
      err_count++; $display("unexpected %0t %h %h", $time, (g), (w)); end end
   logic        pclk, presetn, psel, penable, pwrite, slv_v;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd_v;
   logic        pready, pslverr, trig, bpin, pwm, irq_a, irq_b;
   int          err_count, checks_done, n;
   logic [7:0]  ev [3] = '{8'h01, 8'h05, 8'h09};
   // Reset rows: address, read value, error flag
   logic [40:0] rows [7] = '{{tpm_pkg::A_MODE_OFS, 32'h0, 1'b0},
      {tpm_pkg::A_DATA_OFS, 16'h0, tpm_pkg::CNT_RST, 1'b0},
      {tpm_pkg::B_MODE_OFS, 24'h0, tpm_pkg::BMODE_RST, 1'b0},
      {tpm_pkg::B_DATA_OFS, 16'h0, tpm_pkg::CNT_RST, 1'b0},
      {tpm_pkg::START_OFS, 32'h0, 1'b0}, {tpm_pkg::IRQ_OFS, 32'h0, 1'b0},
      {8'h18, 32'h0, 1'b1}};
   tpm_timer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .timer_a_trigger_input(trig),
      .timer_b_input_pin(bpin), .timer_a_pulse_output(pwm),
      .timer_a_irq(irq_a), .timer_b_irq(irq_b));
   tpm_pin_model pins (.clk(pclk), .trig, .bpin);
   // 40 MHz clock
   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // One APB transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      slv_v = pslverr;
      rd_v = prdata;
      {psel, penable} <= 2'b00;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   // Read data stands at the access edge and is taken there
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic count_hi(input int c);
      n = 0;
      repeat (c) begin @(posedge pclk); n += int'(pwm); end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Watchdog: the whole run needs a few thousand cycles
   initial
   begin
      repeat (20000) @(posedge pclk);
      err_count++;
      tally_and_finish();
   end
   // Main sequence
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i])
      begin
         rd(rows[i][40:33]);
         `CHK(rd_v, rows[i][32:1])
         `CHK(slv_v, rows[i][0])
      end
      wr(tpm_pkg::B_MODE_OFS, 32'h0);
      wr(tpm_pkg::B_DATA_OFS, 32'h4);
      wr(tpm_pkg::START_OFS, 32'h2);
      n = 0;
      while (irq_b !== 1'b1 && n < 40) begin n++; @(posedge pclk); end
      `CHK(irq_b, 1'b1)
      wr(tpm_pkg::START_OFS, 32'h0);
      wr(tpm_pkg::IRQ_OFS, 32'h2);
      @(posedge pclk);
      `CHK(irq_b, 1'b0)
      foreach (ev[i])
      begin
         wr(tpm_pkg::B_MODE_OFS, {24'h0, ev[i]});
         wr(tpm_pkg::B_DATA_OFS, 32'h3);
         wr(tpm_pkg::START_OFS, 32'h2);
         pins.wave(5, 5, 2);
         `CHK(irq_b, ev[i] == 8'h09)
         wr(tpm_pkg::START_OFS, 32'h0);
         wr(tpm_pkg::IRQ_OFS, 32'h2);
      end
      wr(tpm_pkg::B_MODE_OFS, 32'h2);
      rd(tpm_pkg::B_MODE_OFS);
      `CHK(rd_v, 32'h2)
      wr(tpm_pkg::START_OFS, 32'h2);
      pins.wave(5, 5, 1);
      `CHK(irq_b, 1'b0)
      pins.wave(5, 5, 2);
      `CHK(irq_b, 1'b1)
      rd(tpm_pkg::B_DATA_OFS);
      `CHK(rd_v == 32'd9 || rd_v == 32'd10, 1'b1)
      wr(tpm_pkg::START_OFS, 32'h0);
      wr(tpm_pkg::B_MODE_OFS, 32'h0a);
      wr(tpm_pkg::START_OFS, 32'h2);
      pins.wave(3, 7, 2);
      rd(tpm_pkg::B_DATA_OFS);
      `CHK(rd_v == 32'd6 || rd_v == 32'd7, 1'b1)
      wr(tpm_pkg::START_OFS, 32'h0);
      wr(tpm_pkg::IRQ_OFS, 32'h3);
      wr(tpm_pkg::A_MODE_OFS, 32'h3f);
      wr(tpm_pkg::A_DATA_OFS, 32'h0301);
      wr(tpm_pkg::START_OFS, 32'h1);
      count_hi(600);
      `CHK(n, 0)
      pins.set_trig(1'b1);
      while (pwm !== 1'b1) @(posedge pclk);
      count_hi(1020);
      `CHK(n, 12)
      `CHK(irq_a, 1'b1)
      rd(tpm_pkg::A_DATA_OFS);
      `CHK(rd_v, 32'h0)
      wr(tpm_pkg::START_OFS, 32'h0);
      wr(tpm_pkg::A_MODE_OFS, 32'h07);
      wr(tpm_pkg::A_DATA_OFS, 32'h4);
      wr(tpm_pkg::START_OFS, 32'h1);
      count_hi(200);
      `CHK(n, 4)
      tally_and_finish();
   end
endmodule
